/* File: rtl/rtcpw_divider.sv */
// Purpose: Programmable divide-by-(coeff+1) tick generator
// Assumes: Input tick is a one-cycle enable
// Notes:   Held in clear while i_hold is high
`timescale 1ns/1ps
module rtcpw_divider #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Control
  input  wire logic         i_hold,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_coeff,
  // Output tick
  output logic              o_tick
);
  logic [W-1:0] cnt_q;
  wire          wrap = (cnt_q >= i_coeff);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (i_hold) begin
      cnt_q <= '0;
    end else if (i_tick) begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
    end
  end

  assign o_tick = i_tick && wrap && !i_hold;
endmodule : rtcpw_divider

/* File: rtl/rtcpw_pkg.sv */
// Purpose: Constants for the prescaler, wakeup and calibration block
// Assumes: 32-bit register port, byte addresses
// Notes:   Status word gathers the event flags of the lower half
//
// How it works
// - Wakeup flag sets at zero, write-zero clears
// - Timestamp event sets stamp flag
// - Second stamp while flagged sets overrun
// - Tamper inputs set bits 13 and 14
// - Calibration write sets pending, locks register
// - Prescaler writable only in init, unprotected
// - Two stage divide: async+1 then sync+1
// - Prescaler resets to 0x7F and 0xFF
// - Reload writable only when allowed, unprotected
// - Enabled timer flags once per period
// - Select bits 2 and 1 both set widen counter to 17 bits
// - First flag one full period after enable
// - Positive code adds about 4 ppm per step; here 2*code extra calendar ticks per 64-tick window
// - Negative code removes about 2 ppm per step; here code async ticks dropped per 64-tick window
// - Direction bit zero speeds, one slows
// - Init mode stops calendar, restarts on clear
// - Write-allowed flag high while timer disabled
package rtcpw_pkg;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
  localparam logic [7:0]  ADDR_PRESCALER = 8'h10;
  localparam logic [7:0]  ADDR_RELOAD    = 8'h14;
  localparam logic [7:0]  ADDR_CALIB     = 8'h18;
  localparam logic [31:0] RST_PRESCALER  = 32'h007F00FF;
  localparam logic [31:0] RST_RELOAD     = 32'h0000FFFF;
  localparam logic [31:0] RST_CALIB      = 32'h00000000;
  localparam int BIT_WR_ALLOWED = 2;
  localparam int BIT_INIT_EN    = 7;
  localparam int BIT_WAKEUP     = 10;
  localparam int BIT_STAMP      = 11;
  localparam int BIT_OVERRUN    = 12;
  localparam int BIT_TAMPER1    = 13;
  localparam int BIT_TAMPER2    = 14;
  localparam int BIT_RECAL      = 16;
  localparam int SYNC_LSB  = 0;
  localparam int SYNC_W    = 15;
  localparam int ASYNC_LSB = 16;
  localparam int ASYNC_W   = 7;
  localparam int CAL_CODE_W  = 5;
  localparam int CAL_DIR_BIT = 7;
  // Coarse calibration window, counted in sync divider ticks (extra calendar ticks excluded)
  localparam logic [7:0] CAL_WINDOW_TICKS = 8'h40;
  // Clock cycles a pending recalibration counts down before applying
  localparam logic [3:0] RECAL_APPLY_CYC = 4'h4;
  typedef enum logic [2:0] {
    RTCPW_WCLK_DIV16, RTCPW_WCLK_DIV8, RTCPW_WCLK_DIV4,
    RTCPW_WCLK_DIV2, RTCPW_WCLK_CAL0, RTCPW_WCLK_CAL1,
    RTCPW_WCLK_CAL2, RTCPW_WCLK_CAL3
  } rtcpw_wclk_t;
endpackage : rtcpw_pkg

/* File: rtl/rtcpw_top.sv */
// Purpose: Prescaler, wakeup timer and coarse calibration of the clock
// Assumes: I_CLOCK is the kernel clock; strobes one cycle long
// Notes:   Write protection comes from outside as a level; init mode is a status bit
`timescale 1ns/1ps
module rtcpw_top
  import rtcpw_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RESETN,
  // Register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Neighbour control
  input  wire logic        I_UNLOCKED,
  input  wire logic        I_WAKEUP_TIMER_ENABLE,
  input  wire logic [2:0]  I_WAKEUP_CLOCK_SELECT,
  // Events
  input  wire logic        I_STAMP_EVENT,
  input  wire logic        I_INTRUSION_ONE_INPUT,
  input  wire logic        I_INTRUSION_TWO_INPUT,
  // Clock ticks and status
  output logic             O_ASYNC_STAGE_TICK,
  output logic             O_CALENDAR_TICK,
  output logic             O_WAKEUP_EVENT_FLAG,
  output logic             O_INIT_MODE
);
  // Register state
  logic [31:0] psc_q;
  logic [15:0] reload_q;
  logic [7:0]  cal_q;
  logic        init_q;
  logic        wake_f_q, stamp_f_q, ovr_f_q, tp1_f_q, tp2_f_q;
  logic        recal_q;
  logic [3:0]  recal_cnt_q;
  logic [7:0]  cal_active_q;
  logic [7:0]  win_q;
  logic [6:0]  adj_q;
  logic [31:0] rdata_q;

  // Decode
  wire wr_sts   = I_WR && (I_ADDR == ADDR_STATUS);
  wire wr_psc   = I_WR && (I_ADDR == ADDR_PRESCALER);
  wire wr_rld   = I_WR && (I_ADDR == ADDR_RELOAD);
  wire wr_cal   = I_WR && (I_ADDR == ADDR_CALIB);
  wire wr_allow = !I_WAKEUP_TIMER_ENABLE;
  wire psc_ok   = wr_psc && init_q && I_UNLOCKED;
  wire rld_ok   = wr_rld && wr_allow && I_UNLOCKED;
  wire cal_ok   = wr_cal && !recal_q && I_UNLOCKED;
  // Write of zero clears; one leaves the flag alone
  wire clr_wake  = wr_sts && !I_WDATA[BIT_WAKEUP];
  wire clr_stamp = wr_sts && !I_WDATA[BIT_STAMP];
  wire clr_ovr   = wr_sts && !I_WDATA[BIT_OVERRUN];
  wire clr_tp1   = wr_sts && !I_WDATA[BIT_TAMPER1];
  wire clr_tp2   = wr_sts && !I_WDATA[BIT_TAMPER2];

  // Two-stage prescaler
  logic async_tick;
  logic sync_tick;
  rtcpw_divider #(.W(ASYNC_W)) u_async (
    .i_clock  (I_CLOCK),
    .i_resetn (I_RESETN),
    .i_hold   (init_q),
    .i_tick   (1'b1),
    .i_coeff  (psc_q[ASYNC_LSB +: ASYNC_W]),
    .o_tick   (async_tick)
  );

  // Coarse calibration: once per window, positive code adds
  // 2*code extra calendar ticks (faster), negative drops code
  // async ticks from the sync count (slower). Granularity, not exact ppm.
  wire        cal_neg  = cal_active_q[CAL_DIR_BIT];
  wire [4:0]  cal_code = cal_active_q[CAL_CODE_W-1:0];
  wire [6:0]  adj_pos  = {1'b0, cal_code, 1'b0};
  wire [6:0]  adj_neg  = {2'b00, cal_code};
  wire        adj_busy = (adj_q != 7'h00);
  wire        stall    = adj_busy && cal_neg && async_tick;
  wire        extra    = adj_busy && !cal_neg && async_tick;
  wire        sync_in  = async_tick && !stall;
  logic       sync_raw;
  rtcpw_divider #(.W(SYNC_W)) u_sync (
    .i_clock  (I_CLOCK),
    .i_resetn (I_RESETN),
    .i_hold   (init_q),
    .i_tick   (sync_in),
    .i_coeff  (psc_q[SYNC_LSB +: SYNC_W]),
    .o_tick   (sync_raw)
  );
  // Positive step: a spare tick goes to the calendar output only, not the divider
  assign sync_tick = sync_raw;
  wire win_end = sync_tick && (win_q == CAL_WINDOW_TICKS - 8'h01);

  // Wakeup clock select
  logic [3:0] kdiv_q;
  logic       wake_tick;
  always_comb begin
    unique case (rtcpw_wclk_t'(I_WAKEUP_CLOCK_SELECT))
      RTCPW_WCLK_DIV16: wake_tick = (kdiv_q == 4'hF);
      RTCPW_WCLK_DIV8:  wake_tick = (kdiv_q[2:0] == 3'h7);
      RTCPW_WCLK_DIV4:  wake_tick = (kdiv_q[1:0] == 2'h3);
      RTCPW_WCLK_DIV2:  wake_tick = kdiv_q[0];
      default:          wake_tick = sync_tick;
    endcase
  end
  wire [16:0] reload17 = {I_WAKEUP_CLOCK_SELECT[2] &
                          I_WAKEUP_CLOCK_SELECT[1], reload_q};
  logic wake_evt;
  rtcpw_wakeup u_wake (
    .i_clock  (I_CLOCK),
    .i_resetn (I_RESETN),
    .i_enable (I_WAKEUP_TIMER_ENABLE),
    .i_tick   (wake_tick),
    .i_reload (reload17),
    .o_event  (wake_evt)
  );

  // Configuration registers
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      psc_q    <= RST_PRESCALER;
      reload_q <= RST_RELOAD[15:0];
      cal_q    <= RST_CALIB[7:0];
      init_q   <= 1'b0;
      kdiv_q   <= 4'h0;
    end else begin
      kdiv_q <= kdiv_q + 4'h1;
      if (wr_sts)
        init_q <= I_WDATA[BIT_INIT_EN];
      if (psc_ok)
        psc_q <= {9'h000, I_WDATA[22:16], 1'b0, I_WDATA[14:0]};
      if (rld_ok)
        reload_q <= I_WDATA[15:0];
      if (cal_ok)
        cal_q <= {I_WDATA[7], 2'b00, I_WDATA[4:0]};
    end
  end

  // Event flags: a set in the clear cycle wins
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wake_f_q  <= 1'b0;
      stamp_f_q <= 1'b0;
      ovr_f_q   <= 1'b0;
      tp1_f_q   <= 1'b0;
      tp2_f_q   <= 1'b0;
    end else begin
      wake_f_q  <= wake_evt || (wake_f_q && !clr_wake);
      stamp_f_q <= I_STAMP_EVENT || (stamp_f_q && !clr_stamp);
      ovr_f_q   <= (I_STAMP_EVENT && stamp_f_q) || (ovr_f_q && !clr_ovr);
      tp1_f_q   <= I_INTRUSION_ONE_INPUT || (tp1_f_q && !clr_tp1);
      tp2_f_q   <= I_INTRUSION_TWO_INPUT || (tp2_f_q && !clr_tp2);
    end
  end

  // Recalibration pending and calibration application
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      recal_q      <= 1'b0;
      recal_cnt_q  <= 4'h0;
      cal_active_q <= RST_CALIB[7:0];
      win_q        <= 8'h00;
      adj_q        <= 7'h00;
    end else begin
      if (cal_ok) begin
        recal_q     <= 1'b1;
        recal_cnt_q <= RECAL_APPLY_CYC;
      end else if (recal_q) begin
        if (recal_cnt_q == 4'h0) begin
          recal_q      <= 1'b0;
          cal_active_q <= cal_q;
        end else begin
          recal_cnt_q <= recal_cnt_q - 4'h1;
        end
      end
      if (sync_tick)
        win_q <= win_end ? 8'h00 : win_q + 8'h01;
      if (win_end)
        adj_q <= cal_neg ? adj_neg : adj_pos;
      else if (stall || extra)
        adj_q <= adj_q - 7'h01;
    end
  end

  // Read mux, data one cycle after the strobe
  wire [31:0] sts_word = {15'h0000, recal_q, 1'b0, tp2_f_q, tp1_f_q,
                          ovr_f_q, stamp_f_q, wake_f_q, 2'b00, init_q,
                          4'h0, wr_allow, 2'b00};
  wire [31:0] rd_mux =
    (I_ADDR == ADDR_STATUS)    ? sts_word :
    (I_ADDR == ADDR_PRESCALER) ? psc_q :
    (I_ADDR == ADDR_RELOAD)    ? {16'h0000, reload_q} :
    (I_ADDR == ADDR_CALIB)     ? {24'h000000, cal_q} : 32'h00000000;

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= I_RD ? rd_mux : 32'h00000000;
  end

  assign O_RDATA             = rdata_q;
  assign O_ASYNC_STAGE_TICK  = async_tick;
  assign O_CALENDAR_TICK     = sync_tick || (extra && !init_q);
  assign O_WAKEUP_EVENT_FLAG = wake_f_q;
  assign O_INIT_MODE         = init_q;

  a_wake_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    wake_evt |=> wake_f_q)
    else $error("Wakeup flag missed its event");
  a_stamp_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_STAMP_EVENT |=> stamp_f_q)
    else $error("Stamp flag missed its event");
  a_overrun_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_STAMP_EVENT && stamp_f_q |=> ovr_f_q)
    else $error("Overrun not flagged");
  a_tamper_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    I_INTRUSION_TWO_INPUT |=> tp2_f_q && sts_word[BIT_TAMPER2])
    else $error("Tamper two not flagged");
  a_recal_lock: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    wr_cal && recal_q |=> $stable(cal_q))
    else $error("Calibration changed while pending");
  a_recal_done: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    cal_ok |-> ##[1:6] !recal_q)
    else $error("Recalibration never applied");
  a_psc_guard: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    wr_psc && !init_q |=> $stable(psc_q))
    else $error("Prescaler written outside init");
  a_rld_guard: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    wr_rld && I_WAKEUP_TIMER_ENABLE |=> $stable(reload_q))
    else $error("Reload written while timer runs");
  a_init_stop: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    init_q |-> !async_tick && !sync_tick)
    else $error("Prescaler ticks in init mode");
  a_keep_one: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
    wr_sts && I_WDATA[BIT_TAMPER1] && tp1_f_q |=> tp1_f_q)
    else $error("Writing one cleared a flag");
endmodule : rtcpw_top

/* File: rtl/rtcpw_wakeup.sv */
// Purpose: Wakeup down-counter with auto-reload
// Assumes: Count tick is a one-cycle enable
// Notes:   Loads on enable so the first event takes a full period
`timescale 1ns/1ps
module rtcpw_wakeup (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // Control
  input  wire logic        i_enable,
  input  wire logic        i_tick,
  input  wire logic [16:0] i_reload,
  // Event
  output logic             o_event
);
  logic [16:0] cnt_q;
  logic        en_q;
  wire         start = i_enable && !en_q;
  wire         zero  = (cnt_q == 17'h00000);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      en_q  <= 1'b0;
    end else begin
      en_q <= i_enable;
      if (start)
        cnt_q <= i_reload;
      else if (en_q && i_tick)
        cnt_q <= zero ? i_reload : cnt_q - 1'b1;
    end
  end

  assign o_event = en_q && i_enable && i_tick && zero;

  a_wake_period: assert property (@(posedge i_clock) disable iff (!i_resetn)
    start |=> (cnt_q == $past(i_reload)))
    else $error("Counter not loaded on enable");
endmodule : rtcpw_wakeup

/* File: verification/tb.sv */
// Purpose: Register-level bench for the prescaler and wakeup block
// Assumes: Design carries its own inline assertions
// Notes:   Rate checks are windows; calibration is only coarse
`timescale 1ns/1ps
module tb
  import rtcpw_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        unl = 1'b1;
  logic        wen = 1'b0;
  logic [2:0]  wsel = 3'h3;
  logic [2:0]  ev = 3'h0;
  logic [31:0] rdata;
  logic        atick;
  logic        ctick;
  logic        wflag;
  logic        initm;
  int          err_count = 0;
  int          checks = 0;
  int          n;

  rtcpw_top dut (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_UNLOCKED(unl),
    .I_WAKEUP_TIMER_ENABLE(wen), .I_WAKEUP_CLOCK_SELECT(wsel),
    .I_STAMP_EVENT(ev[0]), .I_INTRUSION_ONE_INPUT(ev[1]),
    .I_INTRUSION_TWO_INPUT(ev[2]), .O_ASYNC_STAGE_TICK(atick),
    .O_CALENDAR_TICK(ctick), .O_WAKEUP_EVENT_FLAG(wflag),
    .O_INIT_MODE(initm)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g,
                     logic [31:0] m = 32'hFFFFFFFF);
    checks++;
    if ((g & m) !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g & m);
    end
  endtask : chk

  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the write settle before any direct look at outputs
    #1;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task automatic rc(string nm, logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata, m);
  endtask : rc

  task automatic cnt(int which, int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      c += (which == 0) ? atick : ((which == 1) ? ctick : wflag);
    end
  endtask : cnt

  task automatic wait_flag(int max, output int c);
    c = 0;
    while (wflag !== 1'b1) begin
      @(posedge clk);
      #1;
      c++;
      if (c > max) begin
        err_count++;
        $display("CHECK FAILED wakeup_wait exp 1 got 0");
        end_sim();
      end
    end
  endtask : wait_flag

  task automatic pulse(logic [2:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse

  task automatic set_wen(logic e, logic [2:0] s);
    @(posedge clk);
    wen  <= e;
    wsel <= s;
  endtask : set_wen

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc("psc_rst", ADDR_PRESCALER, RST_PRESCALER);
    rc("rld_rst", ADDR_RELOAD, RST_RELOAD);
    rc("cal_rst", ADDR_CALIB, RST_CALIB);
    rc("sts_rst", ADDR_STATUS, 32'h00000004);
    rc("unmapped", 8'h3C, 32'h00000000);
    reg_wr(ADDR_PRESCALER, 32'h00030001);
    rc("psc_noinit", ADDR_PRESCALER, RST_PRESCALER);
    reg_wr(ADDR_STATUS, 32'h00000080);
    chk("init_mode", 32'h1, {31'h0, initm});
    cnt(1, 40, n);
    chk("cal_stopped", 32'h0, 32'(n));
    @(posedge clk);
    unl <= 1'b0;
    reg_wr(ADDR_PRESCALER, 32'h00030001);
    rc("psc_locked", ADDR_PRESCALER, RST_PRESCALER);
    @(posedge clk);
    unl <= 1'b1;
    reg_wr(ADDR_PRESCALER, 32'hFFFFFFFF);
    rc("psc_resv", ADDR_PRESCALER, 32'h007F7FFF);
    reg_wr(ADDR_PRESCALER, 32'h00030001);
    rc("psc_init", ADDR_PRESCALER, 32'h00030001);
    reg_wr(ADDR_STATUS, 32'h00000000);
    cnt(0, 40, n);
    chk("async_rate", 32'd10, 32'(n));
    cnt(1, 1024, n);
    chk("cal_rate", 32'h1, 32'(n >= 127 && n <= 129));
    // Period 16 ticks of clock/2: room to clear before it sets again
    reg_wr(ADDR_RELOAD, 32'h0000000F);
    rc("rld_wr", ADDR_RELOAD, 32'h0000000F);
    set_wen(1'b1, 3'h3);
    wait_flag(40, n);
    chk("wake_first", 32'h1, 32'(n >= 30 && n <= 34));
    rc("sts_wake", ADDR_STATUS, 32'h00000400, 32'h00000404);
    reg_wr(ADDR_RELOAD, 32'h00000005);
    rc("rld_busy", ADDR_RELOAD, 32'h0000000F);
    reg_wr(ADDR_STATUS, 32'hFFFFFF7F);
    rc("wake_keep", ADDR_STATUS, 32'h00000400, 32'h00000400);
    reg_wr(ADDR_STATUS, 32'hFFFFFB7F);
    rc("wake_clr", ADDR_STATUS, 32'h00000000, 32'h00000400);
    wait_flag(40, n);
    chk("wake_again", 32'h1, {31'h0, wflag});
    set_wen(1'b0, 3'h4);
    reg_wr(ADDR_STATUS, 32'hFFFFFB7F);
    reg_wr(ADDR_RELOAD, 32'h00000001);
    set_wen(1'b1, 3'h4);
    wait_flag(40, n);
    chk("wake_cal", 32'h1, 32'(n >= 12 && n <= 20));
    set_wen(1'b0, 3'h6);
    reg_wr(ADDR_STATUS, 32'hFFFFFB7F);
    set_wen(1'b1, 3'h6);
    cnt(2, 80, n);
    chk("wake_17bit", 32'h0, 32'(n));
    set_wen(1'b0, 3'h3);
    pulse(3'h1);
    rc("stamp", ADDR_STATUS, 32'h00000800, 32'h00001800);
    pulse(3'h1);
    rc("overrun", ADDR_STATUS, 32'h00001800, 32'h00001800);
    reg_wr(ADDR_STATUS, 32'hFFFFF77F);
    rc("stamp_clr", ADDR_STATUS, 32'h00001000, 32'h00001800);
    reg_wr(ADDR_STATUS, 32'hFFFFEF7F);
    rc("ovr_clr", ADDR_STATUS, 32'h00000000, 32'h00001800);
    pulse(3'h6);
    rc("tamper", ADDR_STATUS, 32'h00006000, 32'h00006000);
    reg_wr(ADDR_STATUS, 32'hFFFFDF7F);
    rc("tamper1_clr", ADDR_STATUS, 32'h00004000, 32'h00006000);
    reg_wr(ADDR_STATUS, 32'hFFFFBF7F);
    rc("tamper2_clr", ADDR_STATUS, 32'h00000000, 32'h00006000);
    // Second write lands while the first is still pending
    reg_wr(ADDR_CALIB, 32'h000000FF);
    reg_wr(ADDR_CALIB, 32'h00000000);
    rc("recal_set", ADDR_STATUS, 32'h00010000, 32'h00010000);
    rc("cal_resv", ADDR_CALIB, 32'h0000009F);
    rc("cal_locked", ADDR_CALIB, 32'h0000009F);
    repeat (10) @(posedge clk);
    rc("recal_done", ADDR_STATUS, 32'h00000000, 32'h00010000);
    cnt(1, 1024, n);
    chk("cal_neg", 32'h1, 32'(n < 126));
    reg_wr(ADDR_CALIB, 32'h0000001F);
    repeat (10) @(posedge clk);
    cnt(1, 1024, n);
    chk("cal_pos", 32'h1, 32'(n > 130));
    end_sim();
  end
endmodule : tb
